// >>> src/clh_host_port.sv
// Character display host port, display memories and write FIFO
`timescale 1ns/1ns
`default_nettype none

module clh_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } clh_fifo_st_t;
   clh_fifo_st_t f_q, f_d;

   assign in_ready = (f_q.cnt != (AW+1)'(D));
   assign out_valid = (f_q.cnt != '0);
   assign out_data = f_q.mem[f_q.rp];

   always_comb begin
      f_d = f_q;
      if (in_valid && in_ready) begin
         f_d.mem[f_q.wp] = in_data;
         f_d.wp = (f_q.wp == AW'(D - 1)) ? '0 : f_q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         f_d.rp = (f_q.rp == AW'(D - 1)) ? '0 : f_q.rp + 1'b1;
      end
      f_d.cnt = f_q.cnt + (AW+1)'(in_valid && in_ready) - (AW+1)'(out_valid && out_ready);
      if (srst) begin
         f_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      f_q <= f_d;
   end
endmodule // clh_fifo

module clh_host_port #(
   parameter int CLEAR_CYCLES = clh_pkg::CLEAR_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host pins
   input wire clh_pkg::clh_pins_t pins_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // Panel scan
   input wire clh_pkg::clh_scan_t scan,
   output logic [4:0] pixel_row,
   // Status
   output logic busy_indicator
);
   typedef struct packed {
      logic [1:0] rs_s;
      logic [1:0] rw_s;
      logic [1:0] e_s;
      logic [1:0][7:0] db_s;
      logic e_prev;
      logic hold_rs;
      logic hold_rw;
      logic [7:0] hold_db;
      clh_pkg::clh_seq_t seq;
      logic [clh_pkg::CNT_W-1:0] cnt;
      logic [6:0] address_pointer;
      logic cg_sel;
      logic inc;
      logic shift_on;
      logic disp_on;
      logic [5:0] disp_shift;
      logic [7:0] data_register;
      logic [clh_pkg::DD_DEPTH-1:0][7:0] display_text_memory;
      logic [clh_pkg::CG_DEPTH-1:0][7:0] custom_glyph_memory;
      logic [7:0] dout;
      logic doe;
      logic [4:0] px;
   } clh_state_t;
   clh_state_t s_q, s_d;

   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic busy;

   // Text addresses 00-27 and 40-67 are packed into 80 flat entries
   function automatic logic [6:0] dd_index(input logic [6:0] a);
      logic [5:0] lo;
      lo = (a[5:0] >= clh_pkg::LINE_LEN) ? a[5:0] - clh_pkg::LINE_LEN : a[5:0];
      dd_index = a[6] ? {1'b0, lo} + clh_pkg::LINE_LEN7 : {1'b0, lo};
   endfunction

   function automatic logic [7:0] rd_mem(input logic sel, input logic [6:0] a);
      rd_mem = sel ? s_q.custom_glyph_memory[a[5:0]] : s_q.display_text_memory[dd_index(a)];
   endfunction

   // Text pointer wraps 27->40 and 67->00; glyph pointer wraps in six bits
   function automatic logic [6:0] ac_step(input logic sel, input logic [6:0] a, input logic up);
      if (sel) begin
         ac_step = up ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
      end else if (up) begin
         ac_step = (a == clh_pkg::DD_LAST_LO) ? clh_pkg::DD_FIRST_HI :
                   (a == clh_pkg::DD_LAST_HI) ? clh_pkg::AC_RST : a + 7'h01;
      end else begin
         ac_step = (a == clh_pkg::AC_RST) ? clh_pkg::DD_LAST_HI :
                   (a == clh_pkg::DD_FIRST_HI) ? clh_pkg::DD_LAST_LO : a - 7'h01;
      end
   endfunction

   function automatic logic [5:0] shift_step(input logic [5:0] v, input logic left);
      if (left) begin
         shift_step = (v == clh_pkg::SHIFT_MAX) ? 6'h00 : v + 6'h01;
      end else begin
         shift_step = (v == 6'h00) ? clh_pkg::SHIFT_MAX : v - 6'h01;
      end
   endfunction

   // Stand-in font: the production glyph table is loaded here in place of this pattern
   function automatic logic [4:0] rom_row(input logic [7:0] code, input logic [2:0] row);
      rom_row = code[4:0] ^ {row, code[6:5]};
   endfunction

   // Write data queue; a full queue refuses the byte and keeps busy high
   clh_fifo #(
      .W(8),
      .D(clh_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(s_q.hold_db),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign busy = (s_q.seq == clh_pkg::ST_BUSY) || fifo_out_valid;
   assign busy_indicator = busy;
   assign data_out = s_q.dout;
   assign data_oe = s_q.doe;
   assign pixel_row = s_q.px;

   logic e_fall;
   logic wr_instr;
   logic rd_data;
   assign e_fall = s_q.e_prev && !s_q.e_s[1];
   assign wr_instr = e_fall && !s_q.hold_rw && !s_q.hold_rs && !busy;
   assign fifo_in_valid = e_fall && !s_q.hold_rw && s_q.hold_rs;
   assign rd_data = e_fall && s_q.hold_rw && s_q.hold_rs && !busy;
   assign fifo_out_ready = (s_q.seq == clh_pkg::ST_IDLE);

   always_comb begin
      logic [6:0] nxt;
      logic [6:0] base;
      logic [6:0] pos;
      logic [6:0] vaddr;
      logic [7:0] code;
      logic [7:0] ins;
      nxt = '0;
      base = '0;
      pos = '0;
      vaddr = '0;
      code = '0;
      ins = s_q.hold_db;
      s_d = s_q;
      // Two-stage synchronisers on every host pin
      s_d.rs_s = {s_q.rs_s[0], pins_in.register_select_line};
      s_d.rw_s = {s_q.rw_s[0], pins_in.read_not_write};
      s_d.e_s = {s_q.e_s[0], pins_in.enable};
      s_d.db_s = {s_q.db_s[0], pins_in.data};
      s_d.e_prev = s_q.e_s[1];
      // Bus value held while enable is high, used at its falling edge
      if (s_q.e_s[1]) begin
         s_d.hold_rs = s_q.rs_s[1];
         s_d.hold_rw = s_q.rw_s[1];
         s_d.hold_db = s_q.db_s[1];
      end
      // Read drive while enable is high
      s_d.doe = s_q.e_s[1] && s_q.rw_s[1];
      s_d.dout = s_q.rs_s[1] ? s_q.data_register : {busy, s_q.address_pointer};
      unique case (s_q.seq)
         clh_pkg::ST_IDLE: begin
            if (fifo_out_valid) begin
               // Queued byte goes into the addressed memory
               if (s_q.cg_sel) begin
                  s_d.custom_glyph_memory[s_q.address_pointer[5:0]] = fifo_out_data;
               end else begin
                  s_d.display_text_memory[dd_index(s_q.address_pointer)] = fifo_out_data;
               end
               s_d.address_pointer = ac_step(s_q.cg_sel, s_q.address_pointer, s_q.inc);
               if (s_q.shift_on && !s_q.cg_sel) begin
                  s_d.disp_shift = shift_step(s_q.disp_shift, s_q.inc);
               end
               s_d.seq = clh_pkg::ST_BUSY;
               s_d.cnt = clh_pkg::CNT_W'(clh_pkg::EXEC_CYC);
            end else if (rd_data) begin
               nxt = ac_step(s_q.cg_sel, s_q.address_pointer, s_q.inc);
               s_d.address_pointer = nxt;
               s_d.data_register = rd_mem(s_q.cg_sel, nxt);
            end else if (wr_instr) begin
               s_d.seq = clh_pkg::ST_BUSY;
               s_d.cnt = clh_pkg::CNT_W'(clh_pkg::EXEC_CYC);
               if (ins[clh_pkg::B_SET_DD]) begin
                  s_d.address_pointer = ins[6:0];
                  s_d.cg_sel = 1'b0;
                  s_d.data_register = rd_mem(1'b0, ins[6:0]);
               end else if (ins[clh_pkg::B_SET_CG]) begin
                  s_d.address_pointer = {1'b0, ins[5:0]};
                  s_d.cg_sel = 1'b1;
                  s_d.data_register = rd_mem(1'b1, {1'b0, ins[5:0]});
               end else if (ins[clh_pkg::B_FUNC]) begin
                  // Interface width and font select are fixed in this build
                  s_d.cnt = clh_pkg::CNT_W'(clh_pkg::EXEC_CYC);
               end else if (ins[clh_pkg::B_SHIFT]) begin
                  if (ins[clh_pkg::F_SC]) begin
                     s_d.disp_shift = shift_step(s_q.disp_shift, !ins[clh_pkg::F_RL]);
                  end else begin
                     s_d.address_pointer = ac_step(s_q.cg_sel, s_q.address_pointer, ins[clh_pkg::F_RL]);
                  end
               end else if (ins[clh_pkg::B_ONOFF]) begin
                  s_d.disp_on = ins[clh_pkg::F_DISP];
               end else if (ins[clh_pkg::B_ENTRY]) begin
                  s_d.inc = ins[clh_pkg::F_ID];
                  s_d.shift_on = ins[clh_pkg::F_SH];
               end else if (ins[clh_pkg::B_HOME]) begin
                  s_d.address_pointer = clh_pkg::AC_RST;
                  s_d.cg_sel = 1'b0;
                  s_d.disp_shift = '0;
                  s_d.cnt = CLEAR_CYCLES[clh_pkg::CNT_W-1:0];
               end else if (ins == clh_pkg::CMD_CLEAR) begin
                  s_d.display_text_memory = {clh_pkg::DD_DEPTH{clh_pkg::BLANK_CHAR}};
                  s_d.address_pointer = clh_pkg::AC_RST;
                  s_d.cg_sel = 1'b0;
                  s_d.inc = clh_pkg::INC_RST;
                  s_d.disp_shift = '0;
                  s_d.cnt = CLEAR_CYCLES[clh_pkg::CNT_W-1:0];
               end
            end
         end
         clh_pkg::ST_BUSY: begin
            // Counting out the execution time; instructions and reads are not taken meanwhile, data writes still queue
            if (s_q.cnt <= clh_pkg::CNT_W'(1)) begin
               s_d.seq = clh_pkg::ST_IDLE;
               s_d.cnt = '0;
            end else begin
               s_d.cnt = s_q.cnt - clh_pkg::CNT_W'(1);
            end
         end
      endcase
      // Panel scan: line base plus column plus shift, wrapped inside 40 entries
      base = clh_pkg::LINE_BASE[scan.line];
      pos = {1'b0, base[5:0]} + {3'b000, scan.col} + {1'b0, s_q.disp_shift};
      if (pos >= clh_pkg::LINE_LEN7) begin
         pos = pos - clh_pkg::LINE_LEN7;
      end
      vaddr = {base[6], pos[5:0]};
      code = s_q.display_text_memory[dd_index(vaddr)];
      if (!s_q.disp_on) begin
         s_d.px = '0;
      end else if (code[7:4] == 4'h0) begin
         s_d.px = s_q.custom_glyph_memory[{code[2:0], scan.row}][4:0];
      end else begin
         s_d.px = rom_row(code, scan.row);
      end
      if (srst) begin
         s_d = '0;
         s_d.seq = clh_pkg::ST_IDLE;
         s_d.address_pointer = clh_pkg::AC_RST;
         s_d.inc = clh_pkg::INC_RST;
         s_d.shift_on = clh_pkg::SHIFT_ON_RST;
         s_d.disp_on = clh_pkg::DISP_ON_RST;
         s_d.display_text_memory = {clh_pkg::DD_DEPTH{clh_pkg::BLANK_CHAR}};
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end
endmodule // clh_host_port

`default_nettype wire

// >>> src/clh_pkg.sv
// Shared constants and types for the character display host port
package clh_pkg;
   // Clock and execution timing
   localparam int CLK_NS = 20;
   localparam int EXEC_NS = 39000;
   localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CLEAR_NS = 1530000;
   localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 17;
   // Memory geometry
   localparam int DD_DEPTH = 80;
   localparam int CG_DEPTH = 64;
   localparam logic [5:0] LINE_LEN = 6'h28;
   localparam logic [6:0] LINE_LEN7 = 7'h28;
   localparam logic [6:0] DD_LAST_LO = 7'h27;
   localparam logic [6:0] DD_FIRST_HI = 7'h40;
   localparam logic [6:0] DD_LAST_HI = 7'h67;
   localparam logic [5:0] SHIFT_MAX = 6'h27;
   localparam logic [3:0][6:0] LINE_BASE = {7'h50, 7'h10, 7'h40, 7'h00};
   localparam int FIFO_DEPTH = 8;
   // Reset values
   localparam logic [7:0] BLANK_CHAR = 8'h20;
   localparam logic [6:0] AC_RST = 7'h00;
   localparam logic INC_RST = 1'b1;
   localparam logic SHIFT_ON_RST = 1'b0;
   localparam logic DISP_ON_RST = 1'b0;
   // Instruction codes, decoded by highest set bit
   localparam logic [7:0] CMD_CLEAR = 8'h01;
   localparam int B_HOME = 1;
   localparam int B_ENTRY = 2;
   localparam int B_ONOFF = 3;
   localparam int B_SHIFT = 4;
   localparam int B_FUNC = 5;
   localparam int B_SET_CG = 6;
   localparam int B_SET_DD = 7;
   localparam int F_ID = 1;
   localparam int F_SH = 0;
   localparam int F_DISP = 2;
   localparam int F_SC = 3;
   localparam int F_RL = 2;
   localparam int F_BUSY = 7;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } clh_seq_t;

   // Host pins as sampled at the block boundary
   typedef struct packed {
      logic register_select_line;
      logic read_not_write;
      logic enable;
      logic [7:0] data;
   } clh_pins_t;

   // Panel scan request
   typedef struct packed {
      logic [1:0] line;
      logic [3:0] col;
      logic [2:0] row;
   } clh_scan_t;
endpackage

// >>> bench/clh_host_port_sva.sv
// Boundary checks for the display host port
`timescale 1ns/1ns
`default_nettype none
module clh_host_port_sva #(
   parameter int CLEAR_CYCLES = clh_pkg::CLEAR_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host pins
   input wire clh_pkg::clh_pins_t pins_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   // Panel scan
   input wire clh_pkg::clh_scan_t scan,
   input wire logic [4:0] pixel_row,
   // Status
   input wire logic busy_indicator
);
   // Ten byte execution times plus one clear is the longest busy stretch allowed
   localparam int BUSY_MAX = 10 * clh_pkg::EXEC_CYC + CLEAR_CYCLES;
   logic [31:0] busy_cnt_q;
   logic [31:0] busy_cnt_d;
   always_comb busy_cnt_d = busy_indicator ? busy_cnt_q + 32'h00000001 : 32'h00000000;
   always_ff @(posedge clk) busy_cnt_q <= srst ? 32'h00000000 : busy_cnt_d;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_oe_rise;
      $rose(pins_in.enable) && pins_in.read_not_write |-> ##3 data_oe;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("read drive late");
   property p_oe_fall;
      $fell(pins_in.enable) |-> ##3 !data_oe;
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("read drive not released");
   property p_oe_read;
      data_oe |-> $past(pins_in.read_not_write, 3) && $past(pins_in.enable, 3);
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("bus driven outside a read");
   property p_busy_hold;
      $rose(busy_indicator) |-> busy_indicator[*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy pulse too short");
   property p_busy_bound;
      busy_cnt_q < BUSY_MAX;
   endproperty
   a_busy_bound: assert property (p_busy_bound) else $error("busy never ends");
   property p_write_busy;
      $fell(pins_in.enable) && !pins_in.read_not_write && !busy_indicator |-> ##[2:6] busy_indicator;
   endproperty
   a_write_busy: assert property (p_write_busy) else $error("write started no work");
   property p_status_busy;
      data_oe && $past(data_oe, 2) && !$past(pins_in.register_select_line, 4) && $stable(busy_indicator)
         && $past(busy_indicator) == $past(busy_indicator, 2) |-> data_out[7] == busy_indicator;
   endproperty
   a_status_busy: assert property (p_status_busy) else $error("status top bit wrong");
   property p_reset_idle;
      $fell(srst) |-> !busy_indicator && !data_oe && pixel_row == 5'h00;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule // clh_host_port_sva

bind clh_host_port clh_host_port_sva #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_clh_host_port_sva (.clk(clk), .srst(srst),
   .pins_in(pins_in), .data_out(data_out), .data_oe(data_oe), .scan(scan), .pixel_row(pixel_row),
   .busy_indicator(busy_indicator));
`default_nettype wire

// >>> bench/clh_host_model.sv
// Host processor model driving the display pin bus
`timescale 1ns/1ns
`default_nettype none
module clh_host_model (
   // Clock
   input wire logic clk,
   // Pin bus
   output var clh_pkg::clh_pins_t pins,
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   logic [7:0] last = 8'h00;
   initial pins = '0;
   // Six clocks a phase, three times what the synchronisers need
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clk);
      pins <= '{rs, rw, 1'b1, rw ? ~last : wd};
      repeat (6) @(posedge clk);
      rd = data_oe ? data_out : ~last;
      pins.enable <= 1'b0;
      last = rw ? rd : wd;
      repeat (6) @(posedge clk);
   endtask
   // Bounded poll; a stuck busy reports failure instead of hanging
   task automatic wait_ready(output bit ok);
      logic [7:0] s;
      ok = 1'b0;
      // Eight queued bytes can keep busy high for over 15000 clocks
      for (int i = 0; i < 2000 && !ok; i++) begin
         xfer(1'b0, 1'b1, 8'h00, s);
         ok = (s[7] === 1'b0);
      end
   endtask
endmodule // clh_host_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the display host port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   clh_pkg::clh_pins_t pins;
   clh_pkg::clh_scan_t scan = '0;
   logic [7:0] data_out;
   logic data_oe;
   logic [4:0] pixel_row;
   logic busy_indicator;
   logic [7:0] r;
   bit ok;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 32'h4767516A;
   int dd[128];
   int cg[64];
   int lb[4] = '{0, 64, 16, 80};
   int ac = 0;
   int cgm = 0;
   int inc = 1;
   int sh = 0;

   always #10 clk = ~clk;

   clh_host_port #(.CLEAR_CYCLES(20)) u_clh_host_port (.clk(clk), .srst(srst), .pins_in(pins),
      .data_out(data_out), .data_oe(data_oe), .scan(scan), .pixel_row(pixel_row), .busy_indicator(busy_indicator));
   clh_host_model u_clh_host_model (.clk(clk), .pins(pins), .data_out(data_out), .data_oe(data_oe));

   task automatic end_sim;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Whole sequence needs about 60000 clocks
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         end_sim;
      end
   end

   function automatic int step(int a);
      if (cgm) return (a + (inc ? 1 : 63)) % 64;
      if (inc) return a == 39 ? 64 : (a == 103 ? 0 : a + 1);
      return a == 64 ? 39 : (a == 0 ? 103 : a - 1);
   endfunction

   task automatic rdy;
      u_clh_host_model.wait_ready(ok);
      if (!ok) begin
         n_errors++;
         end_sim;
      end
   endtask

   task automatic cmd(input logic [7:0] c);
      int t;
      rdy;
      u_clh_host_model.xfer(1'b0, 1'b0, c, r);
      if (c[7]) begin
         ac = c[6:0];
         cgm = 0;
      end else if (c[6]) begin
         ac = c[5:0];
         cgm = 1;
      end else if (c[7:2] == 6'h01) begin
         inc = c[1];
      end else if (c[7:4] == 4'h1) begin
         if (c[3]) begin
            sh = c[2] ? sh - 1 : sh + 1;
         end else begin
            t = inc;
            inc = c[2];
            ac = step(ac);
            inc = t;
         end
      end else if (c[7:1] == 7'h01) begin
         ac = 0;
         cgm = 0;
         sh = 0;
      end else if (c == 8'h01) begin
         foreach (dd[i])
            dd[i] = 32'h20;
         ac = 0;
         cgm = 0;
         inc = 1;
         sh = 0;
      end
   endtask

   // Writes do not wait: while busy they queue in the write buffer
   task automatic wr(input logic [7:0] d);
      u_clh_host_model.xfer(1'b1, 1'b0, d, r);
      if (cgm) cg[ac] = d;
      else dd[ac] = d;
      ac = step(ac);
   endtask

   task automatic rd_chk;
      rdy;
      u_clh_host_model.xfer(1'b1, 1'b1, 8'h00, r);
      chk(r, 8'(cgm ? cg[ac] : dd[ac]));
      ac = step(ac);
   endtask

   task automatic st_chk;
      rdy;
      u_clh_host_model.xfer(1'b0, 1'b1, 8'h00, r);
      chk(r, 8'(ac));
   endtask

   // Only valid where the scanned cell holds a custom glyph code
   task automatic pix_chk(input int l, input int c);
      int a;
      rdy;
      a = ((lb[l] % 64) + c + sh + 40) % 40 + (lb[l] / 64) * 64;
      for (int row = 0; row < 8; row++) begin
         @(posedge clk);
         scan <= '{2'(l), 4'(c), 3'(row)};
         repeat (2) @(posedge clk);
         chk({3'h0, pixel_row}, 8'(cg[(dd[a] % 8) * 8 + row] % 32));
      end
   endtask

   initial begin
      foreach (dd[i])
         dd[i] = 32'h20;
      foreach (cg[i])
         cg[i] = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (5) @(posedge clk);
      st_chk;
      cmd(8'hA6);
      st_chk;
      for (int i = 0; i < 3; i++)
         wr(8'($random(seed)));
      st_chk;
      cmd(8'hA6);
      for (int i = 0; i < 3; i++)
         rd_chk;
      cmd(8'h80);
      u_clh_host_model.xfer(1'b0, 1'b1, 8'h00, r);
      chk({7'h00, r[7]}, 8'h01);
      u_clh_host_model.xfer(1'b0, 1'b0, 8'h85, r);
      st_chk;
      cmd(8'h04);
      wr(8'h02);
      wr(8'h01);
      st_chk;
      cmd(8'h06);
      cmd(8'h48);
      for (int i = 0; i < 8; i++)
         wr(8'($random(seed)));
      st_chk;
      cmd(8'h48);
      for (int i = 0; i < 2; i++)
         rd_chk;
      cmd(8'hCF);
      wr(8'h09);
      cmd(8'h0C);
      pix_chk(1, 15);
      cmd(8'h18);
      pix_chk(1, 14);
      cmd(8'h1C);
      cmd(8'h1C);
      pix_chk(1, 0);
      cmd(8'h01);
      cmd(8'h80);
      rd_chk;
      cmd(8'h02);
      st_chk;
      cmd(8'h14);
      st_chk;
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
